// ==== fblc_cfg.svh ====
// register address, field positions, reset values and decode constants
// assumes inclusion by each design file that needs it; the package does not include it
`ifndef FBLC_CFG_SVH
`define FBLC_CFG_SVH

`define FBLC_ADDR_W 4
`define FBLC_OFS_CTRL 4'h0
`define FBLC_OFS_STATUS 4'h1
`define FBLC_BRK_HI 6
`define FBLC_BRK_LO 4
`define FBLC_SPD_HI 3
`define FBLC_SPD_LO 2
`define FBLC_GAIN_HI 1
`define FBLC_GAIN_LO 0
`define FBLC_RST_BRK 3'h3
`define FBLC_RST_SPD 2'h1
`define FBLC_RST_GAIN 2'h2
`define FBLC_RST_RATIO 5'h04
`define FBLC_RST_ONEHOT 4'h2
`define FBLC_RST_BEMF 12'h000
`define FBLC_BRK_OFF 3'h7
`define FBLC_CTRL_MASK 8'h7F
`define FBLC_BAD_DATA 32'hDEAD_0000

`endif

// ==== fblc_decode.sv ====
// decodes the stored field codes into the loop's working values
// assumes fields come from registers in the same clock domain
`timescale 1ns/10ps
`include "fblc_cfg.svh"
module fblc_decode (
    fblc_fields_if.dec f,                      // stored field codes
    output fblc_pkg::fblc_ratio_t ratio,       // braking ratio multiple
    output logic brakeEnable,                  // braking feedback allowed
    output logic [3:0] speedOneHot,            // loop settling speed
    output fblc_pkg::fblc_gain_t gainHundredths // back-emf gain x100
);
    always_comb begin
        brakeEnable = (f.brakeCode != `FBLC_BRK_OFF);
        case (f.brakeCode)
            3'h0: ratio = 5'h01;
            3'h1: ratio = 5'h02;
            3'h2: ratio = 5'h03;
            3'h3: ratio = 5'h04;
            3'h4: ratio = 5'h06;
            3'h5: ratio = 5'h08;
            3'h6: ratio = 5'h10;
            default: ratio = 5'h00;
        endcase
    end

    // code 0 slowest, code 3 fastest and least stable
    always_comb begin
        speedOneHot = 4'h0;
        speedOneHot[f.speedCode] = 1'b1;
    end

    // code 3 is undefined; it is treated as the highest gain
    always_comb begin
        case ({f.resonantMode, f.gainCode})
            3'b100: gainHundredths = 12'h1F4;
            3'b101: gainHundredths = 12'h3E8;
            3'b000: gainHundredths = 12'h022;
            3'b001: gainHundredths = 12'h069;
            3'b010: gainHundredths = 12'h0B6;
            3'b011: gainHundredths = 12'h0B6;
            default: gainHundredths = 12'h7D0;
        endcase
    end
endmodule

// ==== fblc_fields_if.sv ====
// carries the stored fields between the register bank and the decoder
// assumes a single clock domain; plain wires only
`timescale 1ns/10ps
interface fblc_fields_if;
    logic [2:0] brakeCode;
    logic [1:0] speedCode;
    logic [1:0] gainCode;
    logic resonantMode;
    modport bank (output brakeCode, output speedCode, output gainCode,
        output resonantMode);
    modport dec (input brakeCode, input speedCode, input gainCode,
        input resonantMode);
endinterface

// ==== fblc_pkg.sv ====
// types shared by the feedback-loop configuration register files
// assumes fblc_cfg.svh is on the include path
package fblc_pkg;
    typedef enum logic [2:0] {
        FBLC_IDLE = 3'b001,
        FBLC_ACK = 3'b010,
        FBLC_HOLD = 3'b100
    } fblc_state_e;

    // braking-to-driving ratio as an integer multiple; 0 means disabled
    typedef logic [4:0] fblc_ratio_t;
    // back-EMF gain in hundredths of x
    typedef logic [11:0] fblc_gain_t;
endpackage

// ==== fblc_reg_top.sv ====
// feedback-loop configuration register with avalon-mm slave port
// assumes one 40 mhz clock, synchronous active-low reset, calibration
// engine and mode strap driven from logic in the same clock domain
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fblc_cfg.svh"
module fblc_reg_top (
    input wire logic clk,                       // 40 mhz clock
    input wire logic resetn,                    // synchronous reset, low
    input wire logic [`FBLC_ADDR_W-1:0] avsAddress, // word address
    input wire logic avsRead,                   // read request
    input wire logic avsWrite,                  // write request
    input wire logic [31:0] avsWritedata,       // write data
    input wire logic [3:0] avsByteenable,       // byte lanes
    output logic [31:0] avsReaddata,            // read data
    output logic avsWaitrequest,                // stall
    output logic [1:0] avsResponse,             // 00 ok, 10 slave error
    input wire logic resonantMode,              // 1 resonant, 0 eccentric
    input wire logic calWrite,                  // calibration result strobe
    input wire logic [1:0] calGain,             // calibration gain code
    output fblc_pkg::fblc_ratio_t brakeRatio,   // braking ratio multiple
    output logic brakeEnable,                   // braking feedback on
    output logic [3:0] loopSpeed,               // one-hot settling speed
    output fblc_pkg::fblc_gain_t bemfGain       // back-emf gain x100
);
    fblc_fields_if fields();
    fblc_pkg::fblc_state_e state;
    logic [2:0] brakingFeedbackRatio;
    logic [1:0] loopSpeedCode;
    logic [1:0] backEmfAmpGain;
    logic calDone;
    fblc_pkg::fblc_ratio_t next_ratio;
    logic next_brakeEnable;
    logic [3:0] next_speed;
    fblc_pkg::fblc_gain_t next_gain;
    logic accept;
    logic wrCtrl;
    logic [7:0] ctrlImage;

    ////////////////////////////////////////////////////////////////////
    // bus handshake: a request waits one cycle, answers the next; one made right after an answer waits two, as hold accepts none
    assign accept = (state == fblc_pkg::FBLC_IDLE) && (avsRead || avsWrite);
    assign wrCtrl = accept && avsWrite && avsByteenable[0] &&
        (avsAddress == `FBLC_OFS_CTRL);
    assign ctrlImage = {1'b0, brakingFeedbackRatio, loopSpeedCode,
        backEmfAmpGain};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= fblc_pkg::FBLC_IDLE;
        end else begin
            case (state)
                fblc_pkg::FBLC_IDLE: begin
                    if (accept) begin
                        state <= fblc_pkg::FBLC_ACK;
                    end
                end
                fblc_pkg::FBLC_ACK: begin
                    state <= fblc_pkg::FBLC_HOLD;
                end
                fblc_pkg::FBLC_HOLD: begin
                    state <= fblc_pkg::FBLC_IDLE;
                end
                default: begin
                    state <= fblc_pkg::FBLC_IDLE;
                end
            endcase
        end
    end

    // waitrequest low only in the ack state, when data is presented
    always_ff @(posedge clk) begin
        if (!resetn) begin
            avsWaitrequest <= 1'b1;
        end else begin
            avsWaitrequest <= !accept;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            avsReaddata <= 32'h0000_0000;
            avsResponse <= 2'h0;
        end else if (accept) begin
            avsResponse <= 2'h0;
            case (avsAddress)
                `FBLC_OFS_CTRL: avsReaddata <= {24'h00_0000, ctrlImage};
                `FBLC_OFS_STATUS: avsReaddata <= {30'h0000_0000,
                    resonantMode, calDone};
                default: begin
                    avsReaddata <= `FBLC_BAD_DATA;
                    avsResponse <= 2'h2;
                end
            endcase
        end else begin
            avsReaddata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration fields
    always_ff @(posedge clk) begin
        if (!resetn) begin
            brakingFeedbackRatio <= `FBLC_RST_BRK;
            loopSpeedCode <= `FBLC_RST_SPD;
        end else if (wrCtrl) begin
            brakingFeedbackRatio <=
                avsWritedata[`FBLC_BRK_HI:`FBLC_BRK_LO];
            loopSpeedCode <= avsWritedata[`FBLC_SPD_HI:`FBLC_SPD_LO];
        end
    end

    // software write wins over a calibration result in the same cycle,
    // so a deliberate override is never lost
    always_ff @(posedge clk) begin
        if (!resetn) begin
            backEmfAmpGain <= `FBLC_RST_GAIN;
        end else if (wrCtrl) begin
            backEmfAmpGain <=
                avsWritedata[`FBLC_GAIN_HI:`FBLC_GAIN_LO];
        end else if (calWrite) begin
            backEmfAmpGain <= calGain;
        end
    end

    // sticky status: set on a calibration result, cleared by a control
    // write with byte lane 0 enabled; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            calDone <= 1'b0;
        end else if (calWrite) begin
            calDone <= 1'b1;
        end else if (wrCtrl) begin
            calDone <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode into the loop's working values, registered for clean outputs
    assign fields.brakeCode = brakingFeedbackRatio;
    assign fields.speedCode = loopSpeedCode;
    assign fields.gainCode = backEmfAmpGain;
    assign fields.resonantMode = resonantMode;

    fblc_decode u_decode (
        .f(fields),
        .ratio(next_ratio),
        .brakeEnable(next_brakeEnable),
        .speedOneHot(next_speed),
        .gainHundredths(next_gain)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            brakeRatio <= `FBLC_RST_RATIO;
            brakeEnable <= 1'b1;
            loopSpeed <= `FBLC_RST_ONEHOT;
            bemfGain <= `FBLC_RST_BEMF;
        end else begin
            brakeRatio <= next_ratio;
            brakeEnable <= next_brakeEnable;
            loopSpeed <= next_speed;
            bemfGain <= next_gain;
        end
    end
endmodule

// ==== fblc_reg_top_monitor.sv ====
// port-level assertions for the feedback-loop configuration register
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`include "fblc_cfg.svh"
module fblc_monitor (
    input wire logic clk, // clock
    input wire logic resetn, // reset, low
    input wire logic [`FBLC_ADDR_W-1:0] avsAddress, // word address
    input wire logic avsRead, // read request
    input wire logic avsWrite, // write request
    input wire logic [31:0] avsReaddata, // read data
    input wire logic avsWaitrequest, // stall
    input wire logic [1:0] avsResponse, // response code
    input wire logic resonantMode, // actuator mode
    input wire fblc_pkg::fblc_ratio_t brakeRatio, // ratio
    input wire logic brakeEnable, // braking on
    input wire logic [3:0] loopSpeed, // one-hot speed
    input wire fblc_pkg::fblc_gain_t bemfGain // gain x100
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    //////////////////////////////
    property p_rsvd;
        !avsWaitrequest && avsAddress == `FBLC_OFS_CTRL
            |-> avsReaddata[31:7] == '0 && avsResponse == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("bit 7 set");
    property p_ratio;
        brakeRatio inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10,
            5'h00};
    endproperty
    a_ratio: assert property (p_ratio) else $error("bad ratio");
    property p_brkOff;
        $past(resetn) |-> brakeEnable == (brakeRatio != 5'h00);
    endproperty
    a_brkOff: assert property (p_brkOff) else $error("brake off");
    property p_speed;
        $past(resetn) |-> $onehot(loopSpeed);
    endproperty
    a_speed: assert property (p_speed) else $error("speed");
    // decode is registered, so the gain follows last cycle's mode
    property p_gain;
        $past(resetn) |-> ($past(resonantMode)
            ? bemfGain inside {12'h1F4, 12'h3E8, 12'h7D0}
            : bemfGain inside {12'h022, 12'h069, 12'h0B6});
    endproperty
    a_gain: assert property (p_gain) else $error("gain");
    property p_rstVal;
        $rose(resetn) |=> brakeRatio == 5'h04 && brakeEnable
            && loopSpeed == 4'h2;
    endproperty
    a_rstVal: assert property (p_rstVal) else $error("reset");
    property p_answer;
        $rose(avsRead || avsWrite) |-> ##[1:3] !avsWaitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse;
        !avsWaitrequest |-> $past(avsRead || avsWrite) ##1 avsWaitrequest;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer");
    property p_unmapped;
        !avsWaitrequest && avsAddress > `FBLC_OFS_STATUS |->
            avsResponse == 2'h2 && avsReaddata == `FBLC_BAD_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    c_read: cover property (avsRead && !avsWaitrequest);
    c_write: cover property (avsWrite && !avsWaitrequest);
    c_brkOff: cover property (!brakeEnable);
endmodule
bind fblc_reg_top fblc_monitor mon (.clk, .resetn, .avsAddress, .avsRead,
    .avsWrite, .avsReaddata, .avsWaitrequest, .avsResponse, .resonantMode,
    .brakeRatio, .brakeEnable, .loopSpeed, .bemfGain);

// ==== fblc_reg_top_test.sv ====
// self-checking bench for the configuration register
// assumes the monitor file is compiled alongside
`timescale 1ns/10ps
`include "fblc_cfg.svh"
module fblc_reg_top_test;
    logic clk, resetn, avsRead, avsWrite, avsWaitrequest, resonantMode;
    logic calWrite, brakeEnable;
    logic [3:0] avsAddress, avsByteenable, loopSpeed;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [1:0] avsResponse, calGain, rsp;
    fblc_pkg::fblc_ratio_t brakeRatio;
    fblc_pkg::fblc_gain_t bemfGain;
    int fails = 0, compares = 0, cycles = 0;
    fblc_reg_top dut (.clk, .resetn, .avsAddress, .avsRead, .avsWrite,
        .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
        .avsResponse, .resonantMode, .calWrite, .calGain, .brakeRatio,
        .brakeEnable, .loopSpeed, .bemfGain);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end
    //////////////////////////////
    task summarize;
        $display("%0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // holds the request until waitrequest is sampled low; only the
    // cycle ceiling above ends a hung wait
    task xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        do begin
            @(posedge clk);
        end while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        rsp = avsResponse;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    //////////////////////////////
    task t_reset;
        xfer(1'b0, `FBLC_OFS_CTRL, '0);
        check(rd, 32'h0000_0036);
        check(32'(brakeRatio), 32'h0000_0004);
        check(32'(loopSpeed), 32'h0000_0002);
        check(32'(bemfGain), 32'h0000_07D0);
        $display("reset test done");
    endtask
    task automatic t_fields;
        logic [4:0] rt[8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08,
            5'h10, 5'h00};
        logic [11:0] gr[4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'h7D0};
        logic [11:0] ge[4] = '{12'h022, 12'h069, 12'h0B6, 12'h0B6};
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            resonantMode <= c[0];
            xfer(1'b1, `FBLC_OFS_CTRL, 32'({1'b1, c, c[1:0], c[2:1]}));
            settle();
            check(32'(brakeRatio), 32'(rt[c]));
            check(32'(brakeEnable), 32'(c != 3'h7));
            check(32'(loopSpeed), 32'(4'h1 << c[1:0]));
            check(32'(bemfGain), 32'(c[0] ? gr[c[2:1]] : ge[c[2:1]]));
            xfer(1'b0, `FBLC_OFS_CTRL, '0);
            check(rd, 32'({1'b0, c, c[1:0], c[2:1]}));
        end
        $display("field test done");
    endtask
    task t_cal;
        @(posedge clk);
        calGain <= 2'h0;
        calWrite <= 1'b1;
        @(posedge clk);
        calWrite <= 1'b0;
        settle();
        check(32'(bemfGain), 32'h0000_01F4);
        xfer(1'b0, `FBLC_OFS_STATUS, '0);
        check(rd, 32'h0000_0003);
        xfer(1'b1, `FBLC_OFS_CTRL, 32'h0000_0001);
        settle();
        check(32'(bemfGain), 32'h0000_03E8);
        xfer(1'b0, `FBLC_OFS_STATUS, '0);
        check(rd, 32'h0000_0002);
        $display("calibration test done");
    endtask
    task t_refuse;
        avsByteenable <= 4'hE;
        xfer(1'b1, `FBLC_OFS_CTRL, '0);
        avsByteenable <= 4'hF;
        xfer(1'b1, `FBLC_OFS_STATUS, '0);
        xfer(1'b0, `FBLC_OFS_CTRL, '0);
        check(rd, 32'h0000_0001);
        xfer(1'b0, 4'h9, '0);
        check(rd, `FBLC_BAD_DATA);
        check(32'(rsp), 32'h0000_0002);
        $display("refusal test done");
    endtask
    initial begin
        {resetn, avsRead, avsWrite, calWrite, calGain} = '0;
        {avsAddress, avsWritedata} = '0;
        resonantMode = 1'b1;
        avsByteenable = 4'hF;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_fields();
        t_cal();
        t_refuse();
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        summarize();
    end
endmodule
